// ===== verilog/pci_csr_pkg.sv
// shared constants, field positions and carrier types for the pci bridge csr block
package pci_csr_pkg;
   // bit positions below are little-endian; printed bit n maps to (width-1-n)
   localparam int ADDR_W = 40;               // system address width
   localparam int DATA_W = 64;               // csr data width
   // system address fields
   localparam int SPC_HI = 35;               // space select, printed [4:5]
   localparam int SPC_LO = 34;
   localparam int PORT_HI = 21;              // dest port, printed 18:19
   localparam int PORT_LO = 20;
   localparam int CHIP_HI = 18;              // chip select, printed 21:23
   localparam int CHIP_LO = 16;
   localparam int IDX_HI = 15;               // csr index, printed [24:39]
   localparam int GRP_HI = 11;               // register group, printed 28:36
   localparam int GRP_LO = 3;
   // register groups (one 64-bit register per group)
   localparam logic [8:0] GRP_CHIP = 9'h000;
   localparam logic [8:0] GRP_MCFG = 9'h001;
   localparam logic [8:0] GRP_MSTAT = 9'h002;
   // chip configuration
   localparam int CHIP_ID_LO = 48;           // part id, printed 0:15
   localparam int CHIP_VER_LO = 44;          // version, printed 16:19
   localparam int CHIP_MDT = 40;             // delayed transactions, printed 23
   // master configuration
   localparam int MC_ARB_LO = 48;            // printed 0:15
   localparam int MC_BUSRST = 40;            // printed 23
   localparam int MC_SPLIT_LO = 32;          // printed 29:31
   localparam int MC_LIM_LO = 16;            // printed 38:47
   localparam int MC_RETRY = 13;             // printed 50
   localparam int MC_SWAP = 12;              // printed 51
   localparam int MC_ROTATE = 9;             // printed 54
   localparam int MC_NOGTO = 8;              // printed 55
   localparam int MC_PERESP = 4;             // printed 59
   localparam int MC_BADADR = 1;             // printed 62
   localparam int MC_BADDAT = 0;             // printed 63
   localparam logic [63:0] MC_WMASK = 64'hffff_0107_0000_3313;
   localparam logic [9:0] LIM_RESET = 10'h3f0;
   localparam logic [9:0] CHAN_TOP = 10'h3fe; // highest ignorable channel
   localparam logic [9:0] CHAN_PER_BLK = 10'h010; // 64 Mbyte of 4 Mbyte channels
   // master status
   localparam int MS_INRST = 63;             // printed 0
   localparam int MS_RDPAR = 60;             // printed 3
   localparam int MS_PERR = 56;              // printed 7
   localparam int MS_MABT = 55;              // printed 8
   localparam int MS_TABT = 52;              // printed 11
   localparam int MS_BROKEN = 51;            // printed 12
   localparam int MS_DEVSEL_LO = 48;         // printed 14:15
   localparam logic [1:0] DEVSEL_MED = 2'h1;
   // timing
   localparam int BROKEN_CLKS = 16;          // idle-grant clocks
   localparam int ARB_UNIT_CLKS = 256;       // arbitration timer step
   // memory operations for write buffer flush
   typedef enum logic [1:0] {
      OP_FULL_PURGE = 2'h0,                  // full_line_purge_write
      OP_FLUSH_LOCK = 2'h1,
      OP_WRITE_MASK = 2'h2,
      OP_MASK_PURGE = 2'h3
   } mem_op_e;
   // host short packet request
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              short_pkt;
      logic              coherent;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } host_req_s;
   // answer to a request
   typedef struct packed {
      logic              valid;
      logic              err;
      logic [DATA_W-1:0] rdata;
   } host_rsp_s;
   // events from the pci master engine
   typedef struct packed {
      logic rd_parity;
      logic perr_seen;
      logic master_abort;
      logic target_abort;
      logic cycle_start;
   } master_ev_s;
   // master configuration controls
   typedef struct packed {
      logic bus_reset;
      logic retry_ctl;
      logic host_swap;
      logic host_rotate;
      logic no_grant_to;
      logic par_resp;
      logic bad_addr_par;
      logic bad_data_par;
   } master_ctl_s;
endpackage

// ===== verilog/tick_div.sv
// divider giving a one-cycle enable pulse every DIV clocks
module tick_div
   import pci_csr_pkg::*;
#(
   parameter int DIV = ARB_UNIT_CLKS
)(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // enable pulse
   output logic      tick
);
   logic [$clog2(DIV)-1:0] cnt_r;           // free-running step counter

   // count up and pulse at wrap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt_r == ($clog2(DIV))'(DIV - 1));
         cnt_r <= (cnt_r == ($clog2(DIV))'(DIV - 1)) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule

// ===== verilog/flush_seq.sv
// write buffer line flush sequencer: full purge, lock-then-mask, or masked purge
module flush_seq
   import pci_csr_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // flush triggers and line state
   input  wire logic trig,
   input  wire logic line_full,
   input  wire logic fast_merge,
   output logic      ready,
   // memory operation
   output logic      op_valid,
   output mem_op_e   op,
   input  wire logic op_done
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_ONE  = 4'h2,                         // single purge op
      S_LOCK = 4'h4,
      S_MASK = 4'h8
   } fstate_e;
   fstate_e st_r;                            // sequencer state

   // step through the merge flow; op holds until memory reports done
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= S_IDLE;
         op_valid <= 1'b0;
         op <= OP_FULL_PURGE;
         ready <= 1'b1;
      end else begin
         unique case (st_r)
            S_IDLE: begin
               if (trig) begin
                  ready <= 1'b0;
                  op_valid <= 1'b1;
                  // full purge only for a complete line; a partial one must merge
                  if (line_full) begin
                     op <= OP_FULL_PURGE;
                     st_r <= S_ONE;
                  end else if (fast_merge) begin
                     op <= OP_MASK_PURGE;
                     st_r <= S_ONE;
                  end else begin
                     op <= OP_FLUSH_LOCK;
                     st_r <= S_LOCK;
                  end
               end
            end
            S_ONE: begin
               if (op_done) begin
                  op_valid <= 1'b0;
                  ready <= 1'b1;
                  st_r <= S_IDLE;
               end
            end
            // masked write only after the lock completes
            S_LOCK: begin
               if (op_done) begin
                  op <= OP_WRITE_MASK;
                  st_r <= S_MASK;
               end
            end
            S_MASK: begin
               if (op_done) begin
                  op_valid <= 1'b0;
                  ready <= 1'b1;
                  st_r <= S_IDLE;
               end
            end
         endcase
      end
   end

   a_lock_then_mask: assert property (@(posedge clk) disable iff (!rst_n)
      op_valid && op == OP_FLUSH_LOCK && op_done |=> op_valid && op == OP_WRITE_MASK)
      else $error("masked write did not follow lock");
   a_fast_single: assert property (@(posedge clk) disable iff (!rst_n)
      ready && trig && !line_full && fast_merge |=> op == OP_MASK_PURGE ##0 op_valid)
      else $error("fast merge did not send masked purge");
   a_partial_nopurge: assert property (@(posedge clk) disable iff (!rst_n)
      ready && trig && !line_full |=> op_valid && op != OP_FULL_PURGE)
      else $error("partial line flushed with full purge");
   c_lock_flow: cover property (@(posedge clk) disable iff (!rst_n)
      op == OP_FLUSH_LOCK && op_done ##1 op == OP_WRITE_MASK && op_done);
endmodule

// ===== verilog/pci_bridge_csr.sv
// pci bridge csr space, master error status, arbitration timer and flush control
module pci_bridge_csr
   import pci_csr_pkg::*;
#(
   parameter logic [15:0] PART_ID   = 16'h5a01, // arbitrary value
   parameter logic [3:0]  VERSION   = 4'h1,     // arbitrary value
   parameter logic [1:0]  MY_PORT   = 2'h0,
   parameter logic [2:0]  MY_CHIP   = 3'h0,
   parameter logic [1:0]  CSR_SPACE = 2'h3
)(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // host packets
   input  wire host_req_s  host_req,
   output host_rsp_s       host_rsp,
   output logic            io_fwd,
   // pci master engine
   input  wire master_ev_s mst_ev,
   input  wire logic       gnt_n_pin,
   input  wire logic       bus_idle_pin,
   output logic            mst_err_resp,
   output logic            err_cause_set,
   output master_ctl_s     mst_ctl,
   // arbitration timeout
   input  wire logic       arb_wait,
   output logic            arb_disable,
   // controller dma window
   input  wire logic       dma_valid,
   input  wire logic [9:0] dma_chan,
   output logic            dma_ignore,
   // write buffer flush
   input  wire logic       wb_last,
   input  wire logic       wb_jump,
   input  wire logic       wb_sync,
   input  wire logic       wb_full,
   input  wire logic       chan_fast,
   output logic            flush_ready,
   output logic            mem_op_valid,
   output mem_op_e         mem_op,
   input  wire logic       mem_op_done
);
   logic        mdt_r;                      // chip config writable bit
   logic [63:0] mcfg_r;                     // master config, writable fields
   logic [9:0]  lim_r;                      // memory space limit
   logic [5:0]  stat_r;                     // sticky master status
   logic [1:0]  gnt_meta_r, idle_meta_r;    // synchroniser first stages
   logic        gnt_s_r, idle_s_r;          // synchronised pins
   logic [4:0]  brk_cnt_r;                  // idle grant counter
   logic [15:0] arb_cnt_r;                  // arbitration timer
   logic        tick;                       // 256-clock step
   logic        hit, csr_sp, bad_pkt, unmap;
   logic [8:0]  grp;
   logic [63:0] rd_word;

   // address decode
   function automatic logic grp_hit(input logic [ADDR_W-1:0] a,
                                    input logic [8:0] g);
      grp_hit = (a[GRP_HI:GRP_LO] == g);
   endfunction

   assign csr_sp = host_req.addr[SPC_HI:SPC_LO] == CSR_SPACE;
   assign grp = host_req.addr[GRP_HI:GRP_LO];
   // route check on port and chip, plus upper index and byte offset zero
   assign hit = host_req.addr[PORT_HI:PORT_LO] == MY_PORT
             && host_req.addr[CHIP_HI:CHIP_LO] == MY_CHIP
             && host_req.addr[IDX_HI:GRP_HI+1] == 4'h0
             && host_req.addr[GRP_LO-1:0] == 3'h0;
   // only noncoherent short packets are legal
   assign bad_pkt = !host_req.short_pkt || host_req.coherent;
   assign unmap = !hit || grp > GRP_MSTAT;

   // read data; unlisted bits stay zero
   always_comb begin
      rd_word = '0;
      if (grp_hit(host_req.addr, GRP_CHIP)) begin
         rd_word[CHIP_ID_LO +: 16] = PART_ID;
         rd_word[CHIP_VER_LO +: 4] = VERSION;
         rd_word[CHIP_MDT] = mdt_r;
      end else if (grp_hit(host_req.addr, GRP_MCFG)) begin
         rd_word = mcfg_r;
         rd_word[MC_LIM_LO +: 10] = lim_r;
      end else if (grp_hit(host_req.addr, GRP_MSTAT)) begin
         rd_word[MS_INRST] = mcfg_r[MC_BUSRST];
         rd_word[MS_RDPAR] = stat_r[0];
         rd_word[MS_PERR] = stat_r[1];
         rd_word[MS_MABT] = stat_r[2];
         rd_word[MS_TABT] = stat_r[3];
         rd_word[MS_BROKEN] = stat_r[4];
         rd_word[MS_DEVSEL_LO +: 2] = DEVSEL_MED;
      end
   end

   // answer every csr-space request one cycle later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rsp <= '0;
         io_fwd <= 1'b0;
      end else begin
         host_rsp.valid <= host_req.valid && csr_sp;
         host_rsp.err <= host_req.valid && csr_sp && (bad_pkt || unmap);
         host_rsp.rdata <= (host_req.valid && csr_sp && !host_req.write
                            && !bad_pkt && !unmap) ? rd_word : '0;
         // i/o space belongs to the pci i/o path, not answered here
         io_fwd <= host_req.valid && !csr_sp;
      end
   end

   logic wr_ok;
   assign wr_ok = host_req.valid && host_req.write && csr_sp && !bad_pkt && !unmap;

   // chip config: only the delayed transaction bit is writable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mdt_r <= 1'b0;
      end else if (wr_ok && grp == GRP_CHIP) begin
         mdt_r <= host_req.wdata[CHIP_MDT];
      end
   end

   // master config: masked store, limit follows the split field
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mcfg_r <= '0;
         lim_r <= LIM_RESET;
      end else if (wr_ok && grp == GRP_MCFG) begin
         mcfg_r <= host_req.wdata & MC_WMASK;
         // each pci i/o block past block 1 takes 16 channels from memory
         lim_r <= LIM_RESET - CHAN_PER_BLK
                  * {7'h0, host_req.wdata[MC_SPLIT_LO +: 3]};
      end
   end

   // controls straight from the config flops
   assign mst_ctl.bus_reset = mcfg_r[MC_BUSRST];
   assign mst_ctl.retry_ctl = mcfg_r[MC_RETRY];
   assign mst_ctl.host_swap = mcfg_r[MC_SWAP];
   assign mst_ctl.host_rotate = mcfg_r[MC_ROTATE];
   assign mst_ctl.no_grant_to = mcfg_r[MC_NOGTO];
   assign mst_ctl.par_resp = mcfg_r[MC_PERESP];
   assign mst_ctl.bad_addr_par = mcfg_r[MC_BADADR];
   assign mst_ctl.bad_data_par = mcfg_r[MC_BADDAT];

   // pin synchronisers
   // grant is active low, so its stages reset to the released level;
   // resetting them to zero would show a phantom grant for two clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gnt_meta_r <= 2'h3;
         idle_meta_r <= 2'h0;
      end else begin
         gnt_meta_r <= {gnt_meta_r[0], gnt_n_pin};
         idle_meta_r <= {idle_meta_r[0], bus_idle_pin};
      end
   end
   assign gnt_s_r = !gnt_meta_r[1];
   assign idle_s_r = idle_meta_r[1];

   // idle grant watchdog; a started cycle restarts it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         brk_cnt_r <= '0;
      end else if (!gnt_s_r || !idle_s_r || mst_ev.cycle_start) begin
         brk_cnt_r <= '0;
      end else if (brk_cnt_r != 5'(BROKEN_CLKS)) begin
         brk_cnt_r <= brk_cnt_r + 1'b1;
      end
   end

   logic brk_evt;
   assign brk_evt = gnt_s_r && idle_s_r && !mst_ev.cycle_start
                 && brk_cnt_r == 5'(BROKEN_CLKS - 1);

   // sticky error status, cleared only by reset
   // no software clear: the status must still explain an error response
   // when the host gets round to reading it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= '0;
      end else begin
         if (mst_ev.rd_parity) stat_r[0] <= 1'b1;
         if (mst_ev.perr_seen && mcfg_r[MC_PERESP]) stat_r[1] <= 1'b1;
         if (mst_ev.master_abort) stat_r[2] <= 1'b1;
         if (mst_ev.target_abort) stat_r[3] <= 1'b1;
         if (brk_evt) stat_r[4] <= 1'b1;
      end
   end

   logic any_err;
   assign any_err = mst_ev.rd_parity || (mst_ev.perr_seen && mcfg_r[MC_PERESP])
                 || mst_ev.master_abort || mst_ev.target_abort || brk_evt;

   // error response and error cause pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_err_resp <= 1'b0;
         err_cause_set <= 1'b0;
      end else begin
         mst_err_resp <= any_err;
         err_cause_set <= any_err;
      end
   end

   // 256-clock step for the arbitration timer
   tick_div #(
      .DIV (ARB_UNIT_CLKS)
   ) u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (tick)
   );

   // arbitration timer; a zero threshold never fires
   // the step phase runs free, so the first step lands 1 to 256 clocks
   // after the wait starts; cheaper than restarting the divider per wait
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arb_cnt_r <= '0;
         arb_disable <= 1'b0;
      end else if (!arb_wait) begin
         arb_cnt_r <= '0;
         arb_disable <= 1'b0;
      end else begin
         if (tick && arb_cnt_r != 16'hffff) arb_cnt_r <= arb_cnt_r + 1'b1;
         arb_disable <= mcfg_r[MC_ARB_LO +: 16] != 16'h0
                     && arb_cnt_r >= mcfg_r[MC_ARB_LO +: 16];
      end
   end

   // dma window check against the stored limit
   // channel 1023 sits above the top bound, so context sram is never dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_ignore <= 1'b0;
      end else begin
         dma_ignore <= dma_valid && dma_chan >= lim_r && dma_chan <= CHAN_TOP;
      end
   end

   // flush on line end, address jump or sync event
   logic flush_trig;
   assign flush_trig = wb_last || wb_jump || wb_sync;

   flush_seq u_flush (
      .clk        (clk),
      .rst_n      (rst_n),
      .trig       (flush_trig),
      .line_full  (wb_full),
      .fast_merge (chan_fast),
      .ready      (flush_ready),
      .op_valid   (mem_op_valid),
      .op         (mem_op),
      .op_done    (mem_op_done)
   );

   // checks
   a_coh_err: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.valid && csr_sp && host_req.coherent |=> host_rsp.valid && host_rsp.err)
      else $error("coherent csr access not refused");
   a_unmap_err: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.valid && csr_sp && grp > GRP_MSTAT |=> host_rsp.err)
      else $error("unmapped csr access without error");
   a_chip_ident: assert property (@(posedge clk) disable iff (!rst_n)
      host_rsp.valid && !host_rsp.err && !$past(host_req.write)
      && $past(grp) == GRP_CHIP |-> host_rsp.rdata[63:44] == {PART_ID, VERSION})
      else $error("chip identity wrong");
   a_limit_upd: assert property (@(posedge clk) disable iff (!rst_n)
      wr_ok && grp == GRP_MCFG && host_req.wdata[MC_SPLIT_LO +: 3] == 3'h0
      |=> lim_r == LIM_RESET)
      else $error("limit not updated from split");
   a_bus_reset: assert property (@(posedge clk) disable iff (!rst_n)
      wr_ok && grp == GRP_MCFG && host_req.wdata[MC_BUSRST] |=> mst_ctl.bus_reset)
      else $error("bus reset output not driven");
   a_perr_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !stat_r[1] && !(mst_ev.perr_seen && mcfg_r[MC_PERESP]) |=> !stat_r[1])
      else $error("perr status set without response enable");
   a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      stat_r[0] |=> stat_r[0] ##1 stat_r[0])
      else $error("parity status lost");
   a_abort_resp: assert property (@(posedge clk) disable iff (!rst_n)
      mst_ev.master_abort || mst_ev.target_abort |=> mst_err_resp && err_cause_set)
      else $error("abort without error response");
   a_broken_16: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(stat_r[4]) |-> $past(brk_cnt_r) == 5'(BROKEN_CLKS - 1))
      else $error("broken device flagged at wrong count");
   a_dma_top: assert property (@(posedge clk) disable iff (!rst_n)
      dma_valid && dma_chan == 10'h3ff |=> !dma_ignore)
      else $error("context channel wrongly ignored");
   // register contents, routing, error reporting and arbitration timer steps
   a_limit_split: assert property (@(posedge clk) disable iff (!rst_n)
      wr_ok && grp == GRP_MCFG |=> lim_r == LIM_RESET - CHAN_PER_BLK
      * {7'h0, $past(host_req.wdata[MC_SPLIT_LO +: 3])})
      else $error("limit does not follow split field");
   a_devsel_fixed: assert property (@(posedge clk) disable iff (!rst_n)
      host_rsp.valid && !host_rsp.err && !$past(host_req.write) && $past(grp) == GRP_MSTAT
      |-> host_rsp.rdata[MS_DEVSEL_LO +: 2] == DEVSEL_MED)
      else $error("select timing field not fixed at one");
   a_chip_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      host_rsp.valid && !host_rsp.err && !$past(host_req.write) && $past(grp) == GRP_CHIP
      |-> host_rsp.rdata[CHIP_VER_LO-1:0] == {3'h0, $past(mdt_r), 40'h0})
      else $error("reserved chip config bits not zero");
   a_rdpar_resp: assert property (@(posedge clk) disable iff (!rst_n)
      mst_ev.rd_parity |=> stat_r[0] && mst_err_resp && err_cause_set)
      else $error("read parity error not reported");
   a_arb_step: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(arb_cnt_r) && arb_cnt_r != 16'h0 |-> $past(tick))
      else $error("arbitration timer moved off a step");
   a_wr_refused: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.valid && host_req.write && csr_sp && (bad_pkt || unmap)
      |=> $stable(mcfg_r) && $stable(lim_r) && $stable(mdt_r))
      else $error("refused write changed a register");
   a_io_fwd: assert property (@(posedge clk) disable iff (!rst_n)
      host_req.valid && !csr_sp |=> io_fwd && !host_rsp.valid)
      else $error("i/o space request not passed on");
   c_csr_write: cover property (@(posedge clk) disable iff (!rst_n)
      wr_ok ##1 host_rsp.valid && !host_rsp.err);
   c_broken: cover property (@(posedge clk) disable iff (!rst_n) $rose(stat_r[4]));
   c_arb_to: cover property (@(posedge clk) disable iff (!rst_n) $rose(arb_disable));
endmodule

// ===== sim/mem_responder.sv
// memory side model that completes bridge flush operations
module mem_responder
   import pci_csr_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // operation handshake
   input  wire logic op_valid,
   input  wire logic slow,
   output logic      op_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt; // clocks an op has waited
   // one done pulse per op, after 1 or 4 clocks; slow answers stress the lock hold
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt     <= 0;
         op_done <= 1'b0;
      end else begin
         op_done <= op_valid && !op_done && cnt >= (slow ? 3 : 0);
         cnt     <= (op_valid && !op_done) ? cnt + 1 : 0;
      end
   end
endmodule

// ===== sim/pci_bridge_csr_tb_top.sv
// self-checking bench for the bridge csr and flush block
module pci_bridge_csr_tb_top
   import pci_csr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst_n = 0, slow = 0;   // clock, reset, memory pace
   host_req_s   req = '0;                       // host packet
   host_rsp_s   rsp;
   master_ev_s  ev = '0;                        // master engine events
   logic        gnt_n = 1, idle = 0, dv = 0, last = 0, jump = 0, sync = 0, full = 0, fast = 0;
   logic [9:0]  ch = '0;
   logic        err_p, cause, dig, frdy, opv, done, er;
   logic        aw = 0, adis, iof;               // arbitration wait, timeout, i/o forward
   master_ctl_s ctl;
   mem_op_e     op;
   mem_op_e     ops[$];                         // ops the memory completed
   logic [63:0] st = 64'h0001_0000_0000_0000;   // status model, devsel one
   logic [63:0] rd, v, e, w;
   logic [15:0] seed = 16'h046f;
   int          err_total = 0, n_tests = 0, n;
   int          pos[4] = '{MS_RDPAR, MS_PERR, MS_MABT, MS_TABT};
   pci_bridge_csr pci_bridge_csr_inst (.clk(clk), .rst_n(rst_n), .host_req(req),
      .host_rsp(rsp), .io_fwd(iof), .mst_ev(ev), .gnt_n_pin(gnt_n), .bus_idle_pin(idle),
      .mst_err_resp(err_p), .err_cause_set(cause), .mst_ctl(ctl), .arb_wait(aw),
      .arb_disable(adis), .dma_valid(dv), .dma_chan(ch), .dma_ignore(dig), .wb_last(last),
      .wb_jump(jump), .wb_sync(sync), .wb_full(full), .chan_fast(fast),
      .flush_ready(frdy), .mem_op_valid(opv), .mem_op(op), .mem_op_done(done));
   mem_responder mem_responder_inst (.clk(clk), .rst_n(rst_n), .op_valid(opv),
      .slow(slow), .op_done(done));
   always #25 clk = ~clk;
   // record each op as memory finishes it
   always @(posedge clk) if (opv && done) ops.push_back(op);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one host packet; bad[0] long packet, bad[1] coherent
   task automatic csr(input logic wr, input logic [8:0] g, input logic [63:0] d,
                      input logic [1:0] bad);
      @(negedge clk);
      req = '{1'b1, wr, !bad[0], bad[1], 40'hc_0000_0000 | 40'(g) << 3, d};
      @(negedge clk);
      req.valid = 1'b0;
      rd = rsp.rdata;
      er = rsp.err;
      chk(64'(rsp.valid), 64'h1);
      chk(64'(er), 64'(bad != 0 || g > GRP_MSTAT));
   endtask
   task automatic pulse(input int k, input logic exp);
      @(negedge clk);
      ev = master_ev_s'(5'h10 >> k);
      @(negedge clk);
      ev = '0;
      chk(64'({err_p, cause}), {62'h0, exp, exp});
   endtask
   // bounded wait on a completion flag
   task automatic wait_on(ref logic f, input int lim);
      for (n = 0; n < lim && !f; n++) @(negedge clk);
      if (!f) begin
         err_total++;
         give_verdict();
      end
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1;
      csr(0, GRP_CHIP, 0, 0); chk(rd, {16'h5a01, 4'h1, 44'h0});
      csr(0, GRP_MCFG, 0, 0); chk(rd, 64'h0000_0000_03f0_0000);
      pulse(1, 0);
      for (int i = 0; i < 4; i++) begin
         v = {seed, ~seed, seed, ~seed};
         seed = lfsr(seed);
         e = v & MC_WMASK;
         e[25:16] = LIM_RESET - {v[34:32], 4'h0};
         csr(1, GRP_MCFG, v, 0);
         csr(0, GRP_MCFG, 0, 0); chk(rd, e);
         chk(64'(ctl), {v[40], v[13], v[12], v[9], v[8], v[4], v[1], v[0]});
      end
      // request outside csr space goes to the i/o path, unanswered here
      @(negedge clk);
      req = '{1'b1, 1'b0, 1'b1, 1'b0, 40'h0, 64'h0};
      @(negedge clk);
      req.valid = 1'b0;
      chk(64'({iof, rsp.valid}), 64'h2);
      // threshold of two steps, parity response on
      csr(1, GRP_MCFG, 64'h0002_0000_0000_0010, 0);
      aw = 1;
      @(negedge clk);
      chk(64'(adis), 64'h0);
      wait_on(adis, 600);
      chk(64'(n > ARB_UNIT_CLKS && n <= 2 * ARB_UNIT_CLKS), 64'h1);
      aw = 0;
      @(negedge clk);
      chk(64'(adis), 64'h0);
      for (int k = 0; k < 4; k++) begin
         pulse(k, 1);
         st[pos[k]] = 1'b1;
         csr(0, GRP_MSTAT, 0, 0); chk(rd, st);
      end
      gnt_n = 0;
      idle = 1;
      repeat (4) @(negedge clk);
      pulse(4, 0);
      wait_on(err_p, 60);
      chk(64'(n), 64'(BROKEN_CLKS));
      gnt_n = 1;
      st[MS_BROKEN] = 1'b1;
      csr(1, GRP_MSTAT, 0, 0);
      csr(0, GRP_MSTAT, 0, 0); chk(rd, st);
      // mid-run reset clears status and configuration
      @(negedge clk);
      rst_n = 0;
      @(negedge clk);
      rst_n = 1;
      st = 64'h0001_0000_0000_0000;
      csr(0, GRP_MSTAT, 0, 0);
      chk(rd, st);
      csr(0, 9'h003, 0, 2'b00); chk(64'(er), 64'h1);
      chk(rd, 64'h0);
      csr(1, GRP_MCFG, '1, 2'b01);
      csr(0, GRP_MCFG, 0, 2'b10);
      csr(0, GRP_MCFG, 0, 0);
      chk(rd, 64'h0000_0000_03f0_0000);
      csr(1, GRP_CHIP, '1, 0);
      csr(0, GRP_CHIP, 0, 0); chk(rd, {16'h5a01, 4'h1, 3'h0, 1'b1, 40'h0});
      foreach (pos[i]) begin
         ch = 10'h3ff - 10'(i == 2 ? 15 : i == 3 ? 16 : i);
         dv = 1;
         @(negedge clk);
         chk(64'(dig), 64'(ch >= 10'h3f0 && ch <= 10'h3fe));
      end
      dv = 0;
      for (int k = 0; k < 6; k++) begin
         ops = {};
         full = (k == 0);
         fast = k[0];
         slow = k[1];
         {last, jump, sync} = 3'b100 >> (k % 3);
         @(negedge clk);
         {last, jump, sync} = 3'b000;
         @(negedge clk);
         wait_on(frdy, 60);
         w = 64'h1;
         foreach (ops[i]) w = {w[61:0], ops[i]};
         // marker bit then two bits per completed op
         chk(w, full ? 64'h4 : fast ? 64'h7 : 64'h16);
      end
      give_verdict();
   end
endmodule
